// ===== verilog/fft_engine.sv
// 128-point transform engine with its sample memories on AHB-Lite.
// Assumes HSEL decodes the window base; word accesses only.
// Notes on behaviour
// - Each run is a radix-2 transform over exactly 128 complex points.
// - Sample memory and control register sit behind one AHB slave port.
// - Even word offsets go to the real memory, odd ones to the imaginary.
// - Sample n is stored at position m, the seven-bit reversal of n.
// - Writing the launch bit while idle starts a run and claims both memories.
// - Memory accesses during a run get a two-cycle AHB error response.
// - The control register can be read at any time, even mid-run.
// - Completion raises an interrupt and results sit where inputs were.
// - A done flag shows completion; a control write clears it unless completion falls in the same cycle.
// - Internal width gives 32-bit inputs seven integer guard bits, one per stage of radix-2 growth.
// - Every result is stored as an IEEE 754 single-precision number.
// - Work values are 55-bit fixed point, 16 fraction bits cut per stage.
// - A run lasts 5126 system clock cycles from start to completion.
`timescale 1ns/1ns
module fft_engine #(
  parameter int RUN_CYCLES = fft_pkg::FFT_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic IRQ
);
  import fft_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_BFLY, ST_CONV, ST_HOLD} fft_state_e;

  logic signed [FIX_W-1:0] mem_re [FFT_POINTS];
  logic signed [FIX_W-1:0] mem_im [FFT_POINTS];
  logic signed [TW_W-1:0] tw_re [HALF_POINTS];
  logic signed [TW_W-1:0] tw_im [HALF_POINTS];
  fft_state_e state, next_state;
  logic busy, next_busy, flag, next_flag, next_irq;
  logic [CNT_W-1:0] run_cnt, next_run_cnt;
  logic [2:0] stage, next_stage;
  logic [5:0] bf_j, next_bf_j;
  logic [IDX_W-1:0] conv_i, next_conv_i;
  logic wr_pend, next_wr_pend, wr_ram, next_wr_ram, wr_ctrl, next_wr_ctrl;
  logic [IDX_W:0] wr_idx, next_wr_idx;
  logic err1, next_err1, next_ready, next_resp;
  logic [31:0] next_rdata;
  logic acc, addr_ram, addr_ctrl, err_req, start_now, done_now;
  logic [IDX_W-1:0] jj, mask, i0, i1;
  logic [5:0] tw_k;
  fft_bfly_if bf ();

  function automatic logic [IDX_W-1:0] bit_rev(input logic [IDX_W-1:0] n);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int b = 0; b < IDX_W; b++) begin
      r[b] = n[IDX_W-1-b];
    end
    return r;
  endfunction

  // Truncating conversion; rounding was traded away for a single cycle
  function automatic logic [31:0] to_float(input logic signed [FIX_W-1:0] v);
    logic [FIX_W-1:0] mag;
    logic [FIX_W-1:0] norm;
    int p;
    mag = v[FIX_W-1] ? FIX_W'(-v) : FIX_W'(v);
    norm = '0;
    p = -1;
    for (int b = 0; b < FIX_W; b++) begin
      if (mag[b]) begin
        p = b;
      end
    end
    if (p < 0) begin
      return 32'h0;
    end
    norm = mag << (FIX_W - 1 - p);
    return {v[FIX_W-1], 8'(p + FLT_BIAS - FRAC_W),
            norm[FIX_W-2 -: MANT_W]};
  endfunction

  // Twiddle table exp(-j*2*pi*k/N) in Q16, built at elaboration
  for (genvar k = 0; k < HALF_POINTS; k++) begin : g_tw
    localparam real ANG = 2.0 * PI * k / FFT_POINTS;
    localparam real CV = $cos(ANG) * TW_ONE;
    localparam real SV = -$sin(ANG) * TW_ONE;
    assign tw_re[k] = TW_W'($rtoi(CV + (CV >= 0.0 ? 0.5 : -0.5)));
    assign tw_im[k] = TW_W'($rtoi(SV + (SV >= 0.0 ? 0.5 : -0.5)));
  end

  // Address-phase decode; a run in progress or starting now blocks RAM
  assign acc = HSEL && HREADY && HTRANS[1];
  assign addr_ram = HADDR[11:10] == RAM_REGION;
  assign addr_ctrl = HADDR[11:0] == CTRL_OFFSET;
  assign start_now = wr_pend && wr_ctrl && HWDATA[CTRL_LAUNCH_BIT] && !busy;
  assign err_req = (addr_ram && (busy || start_now))
                   || (!addr_ram && !addr_ctrl);
  assign done_now = busy && run_cnt == CNT_W'(RUN_CYCLES - 1);

  // Butterfly pair for stage s, index j; twiddle step shrinks per stage
  assign jj = {1'b0, bf_j};
  assign mask = IDX_W'((7'h1 << stage) - 7'h1);
  assign i0 = IDX_W'((jj >> stage) << (stage + 3'h1)) | (jj & mask);
  assign i1 = i0 | IDX_W'(7'h1 << stage);
  assign tw_k = 6'((jj & mask) << (3'h6 - stage));
  assign bf.a_re = mem_re[i0];
  assign bf.a_im = mem_im[i0];
  assign bf.b_re = mem_re[i1];
  assign bf.b_im = mem_im[i1];
  assign bf.w_re = tw_re[tw_k];
  assign bf.w_im = tw_im[tw_k];

  fft_butterfly u_bfly (
    .bf(bf)
  );

  // Next values for bus, run control and sequencing
  always_comb begin
    next_state = state;
    next_busy = busy;
    next_run_cnt = run_cnt;
    next_flag = flag;
    next_irq = 1'b0;
    next_stage = stage;
    next_bf_j = bf_j;
    next_conv_i = conv_i;
    next_wr_pend = acc && HWRITE && !err_req;
    next_wr_ram = addr_ram;
    next_wr_ctrl = addr_ctrl;
    next_wr_idx = {bit_rev(HADDR[9:3]), HADDR[2]};
    next_err1 = acc && err_req;
    next_ready = !(acc && err_req);
    next_resp = (acc && err_req) || err1;
    next_rdata = 32'h0;
    if (acc && !HWRITE && !err_req) begin
      if (addr_ctrl) begin
        next_rdata[CTRL_LAUNCH_BIT] = busy;
        next_rdata[CTRL_DONE_BIT] = flag;
      end else if (wr_pend && wr_ram && wr_idx == HADDR[9:2]) begin
        next_rdata = HWDATA;
      end else if (HADDR[2]) begin
        next_rdata = mem_im[HADDR[9:3]][FRAC_W +: SAMPLE_W];
      end else begin
        next_rdata = mem_re[HADDR[9:3]][FRAC_W +: SAMPLE_W];
      end
    end
    if (wr_pend && wr_ctrl) begin
      next_flag = 1'b0;
    end
    if (start_now) begin
      next_busy = 1'b1;
      next_run_cnt = '0;
      next_state = ST_BFLY;
      next_stage = '0;
      next_bf_j = '0;
    end else if (busy) begin
      next_run_cnt = run_cnt + 1'b1;
      case (state)
        ST_BFLY: begin
          next_bf_j = bf_j + 1'b1;
          if (bf_j == 6'(HALF_POINTS - 1)) begin
            if (stage == 3'(STAGES - 1)) begin
              next_state = ST_CONV;
              next_conv_i = '0;
            end else begin
              next_stage = stage + 1'b1;
            end
          end
        end
        ST_CONV: begin
          next_conv_i = conv_i + 1'b1;
          if (conv_i == IDX_W'(FFT_POINTS - 1)) begin
            next_state = ST_HOLD;
          end
        end
        ST_HOLD: next_state = ST_HOLD;
        default: next_state = ST_IDLE;
      endcase
      if (done_now) begin
        next_busy = 1'b0;
        next_state = ST_IDLE;
        next_flag = 1'b1;
        next_irq = 1'b1;
      end
    end
  end

  // Register stage for control state and bus outputs
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      run_cnt <= '0;
      flag <= 1'b0;
      IRQ <= 1'b0;
      stage <= '0;
      bf_j <= '0;
      conv_i <= '0;
      wr_pend <= 1'b0;
      wr_ram <= 1'b0;
      wr_ctrl <= 1'b0;
      wr_idx <= '0;
      err1 <= 1'b0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0;
    end else begin
      state <= next_state;
      busy <= next_busy;
      run_cnt <= next_run_cnt;
      flag <= next_flag;
      IRQ <= next_irq;
      stage <= next_stage;
      bf_j <= next_bf_j;
      conv_i <= next_conv_i;
      wr_pend <= next_wr_pend;
      wr_ram <= next_wr_ram;
      wr_ctrl <= next_wr_ctrl;
      wr_idx <= next_wr_idx;
      err1 <= next_err1;
      HREADYOUT <= next_ready;
      HRESP <= next_resp;
      HRDATA <= next_rdata;
    end
  end

  // Memories in place; bus writes only land while the engine is idle
  always_ff @(posedge CLOCK) begin
    if (busy && state == ST_BFLY) begin
      mem_re[i0] <= bf.y0_re;
      mem_im[i0] <= bf.y0_im;
      mem_re[i1] <= bf.y1_re;
      mem_im[i1] <= bf.y1_im;
    end else if (busy && state == ST_CONV) begin
      mem_re[conv_i] <= {7'h0, to_float(mem_re[conv_i]), 16'h0};
      mem_im[conv_i] <= {7'h0, to_float(mem_im[conv_i]), 16'h0};
    end else if (wr_pend && wr_ram) begin
      // Sign extension into Q16 with seven guard bits of headroom
      if (wr_idx[0]) begin
        mem_im[wr_idx[IDX_W:1]] <= {{(INT_W-SAMPLE_W){HWDATA[31]}},
                                    HWDATA, 16'h0};
      end else begin
        mem_re[wr_idx[IDX_W:1]] <= {{(INT_W-SAMPLE_W){HWDATA[31]}},
                                    HWDATA, 16'h0};
      end
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  chk_err_second: assert property (
    (HRESP && !HREADYOUT) |=> (HRESP && HREADYOUT))
    else $error("error response not two cycles");
  chk_busy_ram_err: assert property (
    (acc && addr_ram && (busy || start_now)) |=> (HRESP && !HREADYOUT))
    else $error("memory access during run not refused");
  chk_run_length: assert property (
    $fell(busy) |-> $past(run_cnt) == CNT_W'(RUN_CYCLES - 1))
    else $error("run length wrong");
  chk_irq_with_flag: assert property (
    $rose(IRQ) |-> (flag && !busy) ##1 !IRQ)
    else $error("interrupt not paired with done flag");
  chk_ctrl_read_ok: assert property (
    (acc && addr_ctrl && !HWRITE) |=>
      (HREADYOUT && !HRESP && HRDATA[0] == $past(busy)))
    else $error("control read refused or wrong");
  chk_flag_clear: assert property (
    (wr_pend && wr_ctrl && !done_now) |=> !flag)
    else $error("control write did not clear done flag");
  chk_start_busy: assert property (
    start_now |=> (busy && state == ST_BFLY && run_cnt == '0))
    else $error("launch did not start a run");
  chk_release_ok: assert property (
    (acc && addr_ram && !busy && !start_now) |=> (HREADYOUT && !HRESP))
    else $error("idle memory access refused");
  chk_bitrev_write: assert property (
    (wr_pend && wr_ram && !wr_idx[0] && !busy) |=>
      mem_re[$past(wr_idx[IDX_W:1])][FRAC_W +: SAMPLE_W] == $past(HWDATA))
    else $error("sample not stored at reversed index");
  chk_rev_index: assert property (
    (acc && HWRITE && addr_ram && !err_req) |=> wr_idx == $past({HADDR[3],
      HADDR[4], HADDR[5], HADDR[6], HADDR[7], HADDR[8], HADDR[9], HADDR[2]}))
    else $error("write index not bit-reversed");
endmodule // fft_engine

// ===== verilog/fft_pkg.sv
// Constants shared by the transform engine and its butterfly unit.
// Assumes a 50 MHz system clock and an AHB-Lite select decoded outside.
package fft_pkg;
  localparam int FFT_POINTS = 128;
  localparam int IDX_W = 7;
  localparam int STAGES = 7;
  localparam int HALF_POINTS = 64;
  localparam int FIX_W = 55;
  localparam int INT_W = 39;
  localparam int FRAC_W = 16;
  localparam int SAMPLE_W = 32;
  localparam int TW_W = 18;
  localparam real TW_ONE = 65536.0;
  localparam real PI = 3.14159265358979;
  localparam int FLT_BIAS = 127;
  localparam int MANT_W = 23;
  // Whole run length in system clock cycles
  localparam int FFT_CYCLES = 5126;
  localparam int CNT_W = 13;
  // Window base; only the low twelve address bits are decoded here
  localparam logic [31:0] BASE_ADDR = 32'hb0000000;
  localparam logic [11:0] CTRL_OFFSET = 12'h400;
  localparam int CTRL_LAUNCH_BIT = 0;
  localparam int CTRL_DONE_BIT = 1;
  localparam logic [1:0] RAM_REGION = 2'h0;
endpackage

// ===== verilog/fft_bfly_if.sv
// Operand and result bundle between the engine and the butterfly unit.
// Purely combinational; the engine samples results into its memories.
`timescale 1ns/1ns
interface fft_bfly_if;
  import fft_pkg::*;
  logic signed [FIX_W-1:0] a_re, a_im, b_re, b_im;
  logic signed [TW_W-1:0] w_re, w_im;
  logic signed [FIX_W-1:0] y0_re, y0_im, y1_re, y1_im;
  modport engine (output a_re, a_im, b_re, b_im, w_re, w_im,
                  input y0_re, y0_im, y1_re, y1_im);
  modport unit (input a_re, a_im, b_re, b_im, w_re, w_im,
                output y0_re, y0_im, y1_re, y1_im);
endinterface // fft_bfly_if

// ===== verilog/fft_butterfly.sv
// Radix-2 butterfly on fixed-point complex values with Q16 twiddles.
// Assumes operands sized so the sums stay within the working width.
`timescale 1ns/1ns
module fft_butterfly (
  fft_bfly_if.unit bf
);
  import fft_pkg::*;
  logic signed [FIX_W+TW_W-1:0] prod_re, prod_im;
  logic signed [FIX_W-1:0] t_re, t_im;

  // Complex product b*w, then the sixteen lowest fraction bits dropped
  assign prod_re = bf.b_re * bf.w_re - bf.b_im * bf.w_im;
  assign prod_im = bf.b_re * bf.w_im + bf.b_im * bf.w_re;
  assign t_re = FIX_W'(prod_re >>> FRAC_W);
  assign t_im = FIX_W'(prod_im >>> FRAC_W);

  // Sum and difference; headroom of 39 integer bits absorbs growth
  assign bf.y0_re = bf.a_re + t_re;
  assign bf.y0_im = bf.a_im + t_im;
  assign bf.y1_re = bf.a_re - t_re;
  assign bf.y1_im = bf.a_im - t_im;
endmodule // fft_butterfly

// ===== testbench/fft_ahb_master.sv
// Processor model: a bus master that makes one word transfer at a time.
// Assumes a single slave, so bus ready is that slave's own ready output.
`timescale 1ns/1ns
module fft_ahb_master (
  input wire logic CLOCK,
  output logic HSEL,
  output logic [31:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HRESP
);
  import fft_pkg::*;

  // Idle bus from time zero
  initial begin
    HSEL = 1'b0;
    HADDR = BASE_ADDR;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HWDATA = 32'h0;
  end

  // Address, then data phase held until ready; no pipelining, for clarity
  task automatic xfer(input logic wr, input logic [11:0] off,
      input logic [31:0] wd, output logic [31:0] rd, output logic err,
      output int waits);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= BASE_ADDR | {20'h0, off};
    @(posedge CLOCK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    waits = 0;
    @(posedge CLOCK);
    while (HREADY !== 1'b1 && waits < 8) begin
      waits++;
      @(posedge CLOCK);
    end
    rd = HRDATA;
    err = HRESP;
    HWDATA <= ~wd; // Released data must not look valid
  endtask
endmodule // fft_ahb_master

// ===== testbench/fft_128_point_engine_tb_top.sv
// Self-checking bench for the transform engine and its bus window.
// Assumes the engine is the only slave, so it drives bus ready itself.
`timescale 1ns/1ns
module fft_128_point_engine_tb_top;
  import fft_pkg::*;
  localparam int RUN = 600;
  localparam logic [31:0] BIG = 32'h7fffffff;
  localparam logic [31:0] BIG_SUM = 32'h527fffff; // 128 * BIG, truncated
  typedef struct packed { int n; int part; logic [31:0] d; } fft_row_s;
  fft_row_s rows [5] = '{'{1, 0, 32'h11111111}, '{1, 1, 32'h80000000},
      '{6, 0, 32'hfffffffe}, '{127, 1, 32'h7fffffff}, '{85, 0, 32'h5a5a5a5a}};
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic HSEL, HWRITE, HREADYOUT, HRESP, IRQ;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS;
  logic err;
  int waits, irq_at;
  int n_mismatch = 0;
  int n_compared = 0;

  always #10 CLOCK = ~CLOCK;

  fft_engine #(.RUN_CYCLES(RUN)) uut (.CLOCK(CLOCK), .RESET(RESET),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ));

  fft_ahb_master bus (.CLOCK(CLOCK), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP));

  // Seven-bit index reversal, worked out here independently
  function automatic logic [6:0] rev7(input logic [6:0] v);
    for (int i = 0; i < 7; i++)
      rev7[i] = v[6-i];
  endfunction

  // Word compare, counted
  task automatic chk32(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One transfer, checking error response and its single wait cycle
  task automatic acc(input logic w, input logic [11:0] off,
      input logic [31:0] d, input logic e, input string what);
    bus.xfer(w, off, d, rd, err, waits);
    chk32(what, {31'h0, e}, {31'h0, err});
    chk32(what, e ? 32'h1 : 32'h0, 32'(waits));
  endtask

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge CLOCK);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge CLOCK);
    RESET <= 1'b0;
    acc(1'b0, CTRL_OFFSET, 32'h0, 1'b0, "ctrl after reset");
    chk32("ctrl after reset", 32'h0, rd);
    chk32("irq after reset", 32'h0, {31'h0, IRQ});
    $display("reset test done");
    foreach (rows[i])
      acc(1'b1, 12'((2 * rows[i].n + rows[i].part) * 4), rows[i].d, 1'b0,
          "sample write");
    foreach (rows[i]) begin
      acc(1'b0, 12'((2 * rev7(7'(rows[i].n)) + rows[i].part) * 4), 32'h0,
          1'b0, "sample read");
      chk32("stored sample", rows[i].d, rd);
    end
    $display("placement test done");
    // Full-scale DC input: only bin 0 is nonzero, so no twiddle error
    for (int k = 0; k < 256; k++)
      acc(1'b1, 12'(k * 4), BIG, 1'b0, "load");
    acc(1'b1, CTRL_OFFSET, 32'h1, 1'b0, "launch");
    fork
      begin
        irq_at = 0;
        do begin
          @(posedge CLOCK);
          irq_at++;
        end while (IRQ !== 1'b1 && irq_at < 2000);
        @(posedge CLOCK);
        chk32("irq pulse", 32'h0, {31'h0, IRQ});
      end
      begin
        acc(1'b0, CTRL_OFFSET, 32'h0, 1'b0, "ctrl read busy");
        chk32("busy flag", 32'h1, rd);
        acc(1'b0, 12'h0, 32'h0, 1'b1, "read while busy");
        acc(1'b1, 12'h3fc, 32'h5, 1'b1, "write while busy");
        acc(1'b1, CTRL_OFFSET, 32'h1, 1'b0, "launch while busy");
      end
    join
    // The pulse set on edge RUN after launch is first seen one edge later
    chk32("run length", 32'(RUN + 1), 32'(irq_at));
    acc(1'b0, CTRL_OFFSET, 32'h0, 1'b0, "ctrl read done");
    chk32("done flag", 32'h2, rd);
    for (int k = 0; k < 256; k++) begin
      acc(1'b0, 12'(k * 4), 32'h0, 1'b0, "result read");
      chk32("result", k < 2 ? BIG_SUM : 32'h0, rd);
    end
    acc(1'b1, CTRL_OFFSET, 32'h0, 1'b0, "ctrl write");
    acc(1'b0, CTRL_OFFSET, 32'h0, 1'b0, "ctrl read");
    chk32("done cleared", 32'h0, rd);
    acc(1'b0, 12'h408, 32'h0, 1'b1, "unmapped read");
    $display("transform test done");
    // Reset in mid-run abandons the run and frees the memories
    acc(1'b1, CTRL_OFFSET, 32'h1, 1'b0, "relaunch");
    repeat (100) @(posedge CLOCK);
    RESET <= 1'b1;
    repeat (3) @(posedge CLOCK);
    RESET <= 1'b0;
    acc(1'b0, CTRL_OFFSET, 32'h0, 1'b0, "ctrl after mid reset");
    chk32("state after mid reset", 32'h0, rd);
    acc(1'b0, 12'h0, 32'h0, 1'b0, "memory after mid reset");
    irq_at = 0;
    repeat (RUN) begin
      @(posedge CLOCK);
      if (IRQ !== 1'b0)
        irq_at++;
    end
    chk32("irq after mid reset", 32'h0, 32'(irq_at));
    $display("mid-run reset test done");
    stop_test();
  end
endmodule // fft_128_point_engine_tb_top
